// ==== pkg/ief_pkg.sv ====
`default_nettype none
package ief_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int VEC_W  = 24;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFF_MAIN = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_EDGE = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_EXT  = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_FLAGS  = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_RSTCTL = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_PORT = 3'h5;

    // Main control register fields.
    localparam int MAIN_GLOBAL   = 7;
    localparam int MAIN_PERIPH   = 6;
    localparam int MAIN_T0IE     = 5;
    localparam int MAIN_I0IE     = 4;
    localparam int MAIN_CHG_EN   = 3;
    localparam int MAIN_T0IF     = 2;
    localparam int MAIN_I0IF     = 1;
    localparam int MAIN_CHG_FLAG = 0;

    // Edge and priority control register fields.
    localparam int EDGE_PUDIS = 7;
    localparam int EDGE_SEL0  = 6;
    localparam int EDGE_T0IP  = 2;
    localparam int EDGE_CHG_PRIO = 0;

    // External interrupt control register fields.
    localparam int EXT_I2IP = 7;
    localparam int EXT_I1IP = 6;
    localparam int EXT_I2IE = 4;
    localparam int EXT_I1IE = 3;
    localparam int EXT_I2IF = 1;
    localparam int EXT_I1IF = 0;

    // Peripheral flag register fields.
    localparam int PIR_PSP  = 7;
    localparam int PIR_ADC  = 6;
    localparam int PIR_RX   = 5;
    localparam int PIR_TX   = 4;
    localparam int PIR_SSP  = 3;
    localparam int PIR_CCP1 = 2;
    localparam int PIR_TMR2 = 1;
    localparam int PIR_TMR1 = 0;

    localparam int RSTCTL_PRIO = 7;

    // Reset values and writable masks.
    localparam logic [DATA_W-1:0] RST_MAIN   = 8'h00;
    localparam logic [DATA_W-1:0] RST_EDGE   = 8'hF5;
    localparam logic [DATA_W-1:0] RST_EXT    = 8'hC0;
    localparam logic [DATA_W-1:0] RST_FLAGS  = 8'h00;
    localparam logic [DATA_W-1:0] WMASK_EDGE = 8'hF5;
    localparam logic [DATA_W-1:0] WMASK_EXT  = 8'hDB;
    localparam logic [DATA_W-1:0] WMASK_FLAGS = 8'hCF;

    localparam logic [VEC_W-1:0] VEC_HIGH = 24'h000008;
    localparam logic [VEC_W-1:0] VEC_LOW  = 24'h000018;

    // Pin indices in the synchronised pin vector.
    localparam int NPIN     = 7;
    localparam int PIN_PORT = 3;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } ief_bus_req_t;

    typedef struct packed {
        logic timer0_overflow;
        logic parallel_port_access;
        logic converter_done;
        logic serial_port_done;
        logic capture_compare_one;
        logic capture_compare_pwm_mode;
        logic timer2_match;
        logic timer1_overflow;
    } ief_periph_ev_t;

endpackage
`default_nettype wire

// ==== rtl/ief_bank.sv ====
// Behaviour
// - Flags set on events regardless of enables.
// - Compat mode: top bit gates all interrupts.
// - Priority mode: top bit enables high, blocks all.
// - Compat mode: bit six gates peripheral interrupts.
// - Priority mode: bit six enables low priority.
// - Main register enable and flag bit layout.
// - Timer0 and ext0 flags sticky until cleared.
// - Port change flag on upper pins change.
// - Persisting mismatch keeps setting; port read ends.
// - Pull-up disable bit overrides port latch values.
// - Edge select bits: one rising, zero falling.
// - Timer0 and port change priority bits.
// - Unimplemented control bits always read zero.
// - Ext2 and ext1 priority bits.
// - Ext2/ext1 enables and sticky flags.
// - Peripheral flags sticky, software cleared.
// - Receive flag read-only, follows buffer full.
// - Transmit flag read-only, follows buffer empty.
// - Capture/compare flag ignored in pulse-width mode.
// - Priority mode bit in reset control, off.
// - Vector high or low by priority.
// - Compat mode sends everything to high vector.
// - Response clears the applicable global enable.
`timescale 1ns/1ps
`default_nettype none
module ief_bank (
    input  wire logic                           clk_i,
    input  wire logic                           arst_n_i,
    input  wire logic                           ce_i,
    input  wire ief_pkg::ief_bus_req_t          bus_i,
    output logic [ief_pkg::DATA_W-1:0]          rdata_o,
    input  wire logic [2:0]                     ext_int_pin_i,
    input  wire logic [3:0]                     change_port_pin_i,
    input  wire logic [7:0]                     port_latch_i,
    input  wire ief_pkg::ief_periph_ev_t        periph_ev_i,
    input  wire logic                           rx_full_i,
    input  wire logic                           tx_empty_i,
    input  wire logic [7:0]                     periph_enable_i,
    input  wire logic [7:0]                     periph_priority_i,
    input  wire logic                           irq_ack_i,
    output logic                                irq_req_o,
    output logic [ief_pkg::VEC_W-1:0]           irq_vector_o,
    output logic [7:0]                          pullup_en_o
);

    logic [ief_pkg::DATA_W-1:0] main_reg;
    logic [ief_pkg::DATA_W-1:0] edge_reg;
    logic [ief_pkg::DATA_W-1:0] ext_reg;
    logic [ief_pkg::DATA_W-1:0] pir_reg;
    logic                       prio_mode;
    logic [3:0]                 port_snap;

    logic [ief_pkg::NPIN-1:0]   pin_raw;
    logic [ief_pkg::NPIN-1:0]   sync1;
    logic [ief_pkg::NPIN-1:0]   sync2;
    logic [ief_pkg::NPIN-1:0]   sync3;
    logic [ief_pkg::NPIN-1:0]   pin_stable;
    logic [ief_pkg::NPIN-1:0]   pin_rise;
    logic [ief_pkg::NPIN-1:0]   pin_fall;
    logic [2:0]                 ext_event;
    logic                       mismatch;

    logic wr_main;
    logic wr_edge;
    logic wr_ext;
    logic wr_pir;
    logic wr_rstctl;
    logic rd_port;
    logic ack_taken;

    logic [ief_pkg::DATA_W-1:0] next_main;
    logic [ief_pkg::DATA_W-1:0] next_ext;
    logic [ief_pkg::DATA_W-1:0] next_pir;
    logic [ief_pkg::DATA_W-1:0] pir_view;
    logic [ief_pkg::DATA_W-1:0] next_rdata;
    logic [7:0]                 pir_pend;
    logic                       p_t0;
    logic                       p_i0;
    logic                       p_rb;
    logic                       p_i1;
    logic                       p_i2;
    logic                       hi_pend;
    logic                       lo_pend;
    logic                       high_req;
    logic                       low_req;
    logic                       compat_req;
    logic                       next_req;
    logic [ief_pkg::VEC_W-1:0]  next_vector;

    assign wr_main   = bus_i.wr && (bus_i.addr == ief_pkg::OFF_MAIN);
    assign wr_edge   = bus_i.wr && (bus_i.addr == ief_pkg::OFF_EDGE);
    assign wr_ext    = bus_i.wr && (bus_i.addr == ief_pkg::OFF_EXT);
    assign wr_pir    = bus_i.wr && (bus_i.addr == ief_pkg::OFF_FLAGS);
    assign wr_rstctl = bus_i.wr && (bus_i.addr == ief_pkg::OFF_RSTCTL);
    assign rd_port   = bus_i.rd && (bus_i.addr == ief_pkg::OFF_PORT);
    assign ack_taken = irq_ack_i && irq_req_o;

    assign pin_raw = {change_port_pin_i, ext_int_pin_i};

    // Each pin passes three flip-flops; a level counts once stages two and three agree.
    for (genvar i = 0; i < ief_pkg::NPIN; i++) begin : g_sync
        always_ff @(posedge clk_i or negedge arst_n_i) begin
            if (!arst_n_i) begin
                sync1[i]      <= 1'b0;
                sync2[i]      <= 1'b0;
                sync3[i]      <= 1'b0;
                pin_stable[i] <= 1'b0;
            end else if (ce_i) begin
                sync1[i] <= pin_raw[i];
                sync2[i] <= sync1[i];
                sync3[i] <= sync2[i];
                if (sync2[i] == sync3[i]) begin
                    pin_stable[i] <= sync3[i];
                end
            end
        end
        assign pin_rise[i] = (sync2[i] == sync3[i]) && sync3[i] && !pin_stable[i];
        assign pin_fall[i] = (sync2[i] == sync3[i]) && !sync3[i] && pin_stable[i];
    end

    // Edge select bits sit at consecutive positions from ext0 downward.
    for (genvar k = 0; k < 3; k++) begin : g_edge
        assign ext_event[k] = edge_reg[ief_pkg::EDGE_SEL0-k] ? pin_rise[k] : pin_fall[k];
    end

    // A mismatch against the value caught at the last port read.
    assign mismatch = (pin_stable[ief_pkg::NPIN-1:ief_pkg::PIN_PORT] != port_snap);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            port_snap <= 4'h0;
        end else if (ce_i && rd_port) begin
            port_snap <= pin_stable[ief_pkg::NPIN-1:ief_pkg::PIN_PORT];
        end
    end

    always_comb begin
        next_main = main_reg;
        if (wr_main) begin
            next_main = bus_i.wdata;
        end
        if (ack_taken) begin
            if (!prio_mode || (irq_vector_o == ief_pkg::VEC_HIGH)) begin
                next_main[ief_pkg::MAIN_GLOBAL] = 1'b0;
            end else begin
                next_main[ief_pkg::MAIN_PERIPH] = 1'b0;
            end
        end
        // Events win over a software clear in the same cycle.
        next_main[ief_pkg::MAIN_T0IF] = next_main[ief_pkg::MAIN_T0IF]
                                        | periph_ev_i.timer0_overflow;
        next_main[ief_pkg::MAIN_I0IF] = next_main[ief_pkg::MAIN_I0IF] | ext_event[0];
        next_main[ief_pkg::MAIN_CHG_FLAG] = next_main[ief_pkg::MAIN_CHG_FLAG] | mismatch;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            main_reg <= ief_pkg::RST_MAIN;
        end else if (ce_i) begin
            main_reg <= next_main;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            edge_reg <= ief_pkg::RST_EDGE;
        end else if (ce_i && wr_edge) begin
            edge_reg <= bus_i.wdata & ief_pkg::WMASK_EDGE;
        end
    end

    always_comb begin
        next_ext = ext_reg;
        if (wr_ext) begin
            next_ext = bus_i.wdata & ief_pkg::WMASK_EXT;
        end
        next_ext[ief_pkg::EXT_I1IF] = next_ext[ief_pkg::EXT_I1IF] | ext_event[1];
        next_ext[ief_pkg::EXT_I2IF] = next_ext[ief_pkg::EXT_I2IF] | ext_event[2];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ext_reg <= ief_pkg::RST_EXT;
        end else if (ce_i) begin
            ext_reg <= next_ext;
        end
    end

    always_comb begin
        next_pir = pir_reg;
        if (wr_pir) begin
            next_pir = bus_i.wdata & ief_pkg::WMASK_FLAGS;
        end
        next_pir[ief_pkg::PIR_PSP]  = next_pir[ief_pkg::PIR_PSP]
                                      | periph_ev_i.parallel_port_access;
        next_pir[ief_pkg::PIR_ADC]  = next_pir[ief_pkg::PIR_ADC]
                                      | periph_ev_i.converter_done;
        next_pir[ief_pkg::PIR_SSP]  = next_pir[ief_pkg::PIR_SSP]
                                      | periph_ev_i.serial_port_done;
        next_pir[ief_pkg::PIR_CCP1] = next_pir[ief_pkg::PIR_CCP1]
                                      | (periph_ev_i.capture_compare_one
                                         && !periph_ev_i.capture_compare_pwm_mode);
        next_pir[ief_pkg::PIR_TMR2] = next_pir[ief_pkg::PIR_TMR2]
                                      | periph_ev_i.timer2_match;
        next_pir[ief_pkg::PIR_TMR1] = next_pir[ief_pkg::PIR_TMR1]
                                      | periph_ev_i.timer1_overflow;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pir_reg <= ief_pkg::RST_FLAGS;
        end else if (ce_i) begin
            pir_reg <= next_pir;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prio_mode <= 1'b0;
        end else if (ce_i && wr_rstctl) begin
            prio_mode <= bus_i.wdata[ief_pkg::RSTCTL_PRIO];
        end
    end

    // Receive and transmit flags are live views of the serial buffers.
    always_comb begin
        pir_view                  = pir_reg;
        pir_view[ief_pkg::PIR_RX] = rx_full_i;
        pir_view[ief_pkg::PIR_TX] = tx_empty_i;
    end

    assign pir_pend = pir_view & periph_enable_i;

    assign p_t0 = main_reg[ief_pkg::MAIN_T0IF] && main_reg[ief_pkg::MAIN_T0IE];
    assign p_i0 = main_reg[ief_pkg::MAIN_I0IF] && main_reg[ief_pkg::MAIN_I0IE];
    assign p_rb = main_reg[ief_pkg::MAIN_CHG_FLAG] && main_reg[ief_pkg::MAIN_CHG_EN];
    assign p_i1 = ext_reg[ief_pkg::EXT_I1IF] && ext_reg[ief_pkg::EXT_I1IE];
    assign p_i2 = ext_reg[ief_pkg::EXT_I2IF] && ext_reg[ief_pkg::EXT_I2IE];

    // External interrupt 0 has no priority bit and is always high priority.
    assign hi_pend = p_i0
                     || (p_t0 && edge_reg[ief_pkg::EDGE_T0IP])
                     || (p_rb && edge_reg[ief_pkg::EDGE_CHG_PRIO])
                     || (p_i1 && ext_reg[ief_pkg::EXT_I1IP])
                     || (p_i2 && ext_reg[ief_pkg::EXT_I2IP])
                     || |(pir_pend & periph_priority_i);
    assign lo_pend = (p_t0 && !edge_reg[ief_pkg::EDGE_T0IP])
                     || (p_rb && !edge_reg[ief_pkg::EDGE_CHG_PRIO])
                     || (p_i1 && !ext_reg[ief_pkg::EXT_I1IP])
                     || (p_i2 && !ext_reg[ief_pkg::EXT_I2IP])
                     || |(pir_pend & ~periph_priority_i);

    assign high_req = main_reg[ief_pkg::MAIN_GLOBAL] && hi_pend;
    assign low_req  = main_reg[ief_pkg::MAIN_GLOBAL] && main_reg[ief_pkg::MAIN_PERIPH]
                      && lo_pend;
    assign compat_req = main_reg[ief_pkg::MAIN_GLOBAL]
                        && (p_t0 || p_i0 || p_rb || p_i1 || p_i2
                            || (main_reg[ief_pkg::MAIN_PERIPH] && |pir_pend));

    always_comb begin
        next_req    = prio_mode ? (high_req || low_req) : compat_req;
        next_vector = (!prio_mode || high_req) ? ief_pkg::VEC_HIGH
                                               : ief_pkg::VEC_LOW;
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            irq_req_o    <= 1'b0;
            irq_vector_o <= ief_pkg::VEC_HIGH;
        end else if (ce_i) begin
            irq_req_o    <= next_req && !ack_taken;
            irq_vector_o <= next_vector;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pullup_en_o <= 8'h00;
        end else if (ce_i) begin
            pullup_en_o <= edge_reg[ief_pkg::EDGE_PUDIS] ? 8'h00 : port_latch_i;
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                ief_pkg::OFF_MAIN: next_rdata = main_reg;
                ief_pkg::OFF_EDGE: next_rdata = edge_reg;
                ief_pkg::OFF_EXT:  next_rdata = ext_reg;
                ief_pkg::OFF_FLAGS:  next_rdata = pir_view;
                ief_pkg::OFF_RSTCTL: next_rdata = {prio_mode, 7'h00};
                ief_pkg::OFF_PORT: next_rdata = {pin_stable[ief_pkg::NPIN-1:ief_pkg::PIN_PORT],
                                                 4'h0};
                default:           next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= 8'h00;
        end else if (ce_i) begin
            rdata_o <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// ==== dv/ief_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module ief_core_model (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic       irq_req_i,
    input  wire logic [3:0] lat_i,
    output logic            irq_ack_o
);
    logic [3:0] wait_cnt;

    // The core answers a pending request lat_i cycles after it first sees it, with a one-cycle acknowledge.
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wait_cnt  <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (irq_ack_o || !irq_req_i) begin
            wait_cnt  <= 4'h0;
            irq_ack_o <= 1'b0;
        end else if (wait_cnt == lat_i) begin
            irq_ack_o <= 1'b1;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule
`default_nettype wire

// ==== dv/ief_bank_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module ief_bank_chk (
    input wire logic                          clk_i,
    input wire logic                          arst_n_i,
    input wire logic                          ce_i,
    input wire ief_pkg::ief_bus_req_t         bus_i,
    input wire logic [ief_pkg::DATA_W-1:0]    rdata_o,
    input wire logic                          rx_full_i,
    input wire logic                          tx_empty_i,
    input wire logic                          irq_ack_i,
    input wire logic                          irq_req_o,
    input wire logic [ief_pkg::VEC_W-1:0]     irq_vector_o,
    input wire logic [7:0]                    pullup_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    logic rd_ok;
    assign rd_ok = ce_i && bus_i.rd;

    unmapped_rd_a: assert property (rd_ok && bus_i.addr > 3'h5 |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    edge_rsvd_a: assert property (rd_ok && bus_i.addr == ief_pkg::OFF_EDGE
        |=> rdata_o[3] == 1'b0 && rdata_o[1] == 1'b0) else $error("edge reserved bits set");
    ext_rsvd_a: assert property (rd_ok && bus_i.addr == ief_pkg::OFF_EXT
        |=> rdata_o[5] == 1'b0 && rdata_o[2] == 1'b0) else $error("ext reserved bits set");
    rstctl_rsvd_a: assert property (rd_ok && bus_i.addr == ief_pkg::OFF_RSTCTL
        |=> rdata_o[6:0] == 7'h00) else $error("reset control low bits set");
    rxtx_follow_a: assert property (rd_ok && bus_i.addr == ief_pkg::OFF_FLAGS
        && $stable(rx_full_i) && $stable(tx_empty_i)
        |=> rdata_o[5:4] == {$past(rx_full_i), $past(tx_empty_i)}) else $error("rx tx flags");
    ack_drop_a: assert property (ce_i && irq_req_o && irq_ack_i |=> !irq_req_o)
        else $error("request kept after ack");
    vec_legal_a: assert property (irq_req_o
        |-> irq_vector_o == ief_pkg::VEC_HIGH || irq_vector_o == ief_pkg::VEC_LOW)
        else $error("illegal vector");
    pullup_off_a: assert property (ce_i && bus_i.wr && bus_i.addr == ief_pkg::OFF_EDGE
        && bus_i.wdata[7] ##1 ce_i |=> pullup_en_o == 8'h00) else $error("pull-ups on");

    cover property (irq_req_o && irq_vector_o == ief_pkg::VEC_LOW);
    cover property (irq_req_o && irq_ack_i);
    cover property (rd_ok && bus_i.addr == ief_pkg::OFF_PORT);
endmodule
bind ief_bank ief_bank_chk ief_bank_chk_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .rx_full_i(rx_full_i), .tx_empty_i(tx_empty_i),
    .irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_vector_o(irq_vector_o),
    .pullup_en_o(pullup_en_o));
`default_nettype wire

// ==== dv/ief_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module ief_bank_tb;
    logic                    clk_i = 0, arst_n_i = 0, ce_i = 1, rx = 0, tx = 0, ack, req;
    ief_pkg::ief_bus_req_t   bus_i = '0;
    ief_pkg::ief_periph_ev_t ev = '0;
    logic [2:0]              ext_pin = 0;
    logic [3:0]              chg_pin = 0, lat = 3;
    logic [7:0]              latch = 0, pen = 0, ppri = 0, d, pu, rdata_o;
    logic [23:0]             vec;
    int                      n_mismatch = 0, num_checks = 0, cycles = 0, i;
    logic [7:0]              rst_v [8] = '{8'h00, 8'hF5, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]              evs [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01};
    logic [7:0]              pirs [6] = '{8'h80, 8'h40, 8'h08, 8'h04, 8'h02, 8'h01};

    always #5 clk_i = ~clk_i;

    ief_bank ief_bank_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .bus_i(bus_i),
        .rdata_o(rdata_o), .ext_int_pin_i(ext_pin), .change_port_pin_i(chg_pin),
        .port_latch_i(latch), .periph_ev_i(ev), .rx_full_i(rx), .tx_empty_i(tx),
        .periph_enable_i(pen), .periph_priority_i(ppri), .irq_ack_i(ack),
        .irq_req_o(req), .irq_vector_o(vec), .pullup_en_o(pu));
    ief_core_model ief_core_model_i (.clk_i(clk_i), .arst_n_i(arst_n_i), .irq_req_i(req),
        .lat_i(lat), .irq_ack_o(ack));

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_i);
        bus_i.wr <= 1; bus_i.addr <= a; bus_i.wdata <= v;
        @(posedge clk_i);
        bus_i.wr <= 0;
    endtask
    task automatic rchk(input string w, input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        bus_i.rd <= 1; bus_i.addr <= a;
        @(posedge clk_i);
        bus_i.rd <= 0;
        @(negedge clk_i);
        chk(w, {16'h0, rdata_o}, {16'h0, e});
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= '0;
    endtask
    task automatic pins(input logic [2:0] e);
        @(posedge clk_i);
        ext_pin <= e;
        repeat (6) @(posedge clk_i);
    endtask
    task automatic irq_seq(input logic [23:0] v, input logic [7:0] m);
        for (i = 0; i < 20 && req !== 1'b1; i++) @(negedge clk_i);
        chk("request raised", {23'h0, req}, 24'h1);
        chk("vector", vec, v);
        for (i = 0; i < 20 && ack !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);
        chk("request after ack", {23'h0, req}, 24'h0);
        rchk("main after ack", 3'h0, m);
    endtask

    task automatic t_regs;
        for (int a = 0; a < 8; a++) rchk("reset value", a[2:0], rst_v[a]);
        wr(1, 8'hFF); rchk("edge mask", 1, 8'hF5);
        wr(2, 8'hFF); rchk("ext mask", 2, 8'hDB);
        wr(2, 8'hC0); wr(6, 8'hFF); rchk("unmapped", 6, 8'h00);
        @(posedge clk_i) ce_i <= 0;
        wr(0, 8'h08);
        @(posedge clk_i) ce_i <= 1;
        rchk("frozen write", 0, 8'h00);
        @(posedge clk_i) latch <= 8'hA5;
        wr(1, 8'h75); repeat (2) @(negedge clk_i); chk("pull-ups", pu, 8'hA5);
        wr(1, 8'hF5); repeat (2) @(negedge clk_i); chk("pull-ups", pu, 8'h00);
    endtask
    task automatic t_flags;
        for (int k = 0; k < 6; k++) begin
            pulse(evs[k]); rchk("flag set", 3, pirs[k]);
            wr(3, 8'h00); rchk("flag clear", 3, 8'h00);
        end
        pulse(8'h0C); rchk("pwm capture", 3, 8'h00);
        @(posedge clk_i) begin rx <= 1; tx <= 1; end
        rchk("rx tx", 3, 8'h30); wr(3, 8'h00); rchk("rx tx kept", 3, 8'h30);
        @(posedge clk_i) begin rx <= 0; tx <= 0; end
        rchk("rx tx low", 3, 8'h00);
        pulse(8'h80); rchk("timer0", 0, 8'h04); rchk("timer0 sticky", 0, 8'h04);
        wr(0, 8'h00);
    endtask
    task automatic t_pins;
        pins(3'h7); rchk("ext0 rise", 0, 8'h02); rchk("ext1 ext2", 2, 8'hC3);
        wr(0, 8'h00); wr(2, 8'hC0); wr(1, 8'h85);
        pins(3'h0); rchk("ext0 fall", 0, 8'h02); rchk("ext fall", 2, 8'hC3);
        wr(0, 8'h00); wr(2, 8'hC0);
        pins(3'h7); rchk("wrong edge", 0, 8'h00); rchk("wrong edge", 2, 8'hC0);
        wr(1, 8'hF5);
        @(posedge clk_i) chg_pin <= 4'h9;
        repeat (6) @(posedge clk_i);
        rchk("port change", 0, 8'h01); wr(0, 8'h00); rchk("mismatch", 0, 8'h01);
        rchk("port read", 5, 8'h90); wr(0, 8'h00); rchk("cleared", 0, 8'h00);
    endtask
    task automatic t_irq;
        // Flags are clear before any enable goes up.
        wr(0, 8'hA0); pulse(8'h80); irq_seq(ief_pkg::VEC_HIGH, 8'h24);
        @(posedge clk_i) pen <= 8'h01;
        wr(0, 8'h40); pulse(8'h01);
        repeat (4) @(negedge clk_i); chk("blocked", {23'h0, req}, 24'h0);
        @(posedge clk_i) lat <= 0;
        wr(0, 8'hC0); irq_seq(ief_pkg::VEC_HIGH, 8'h40);
        wr(4, 8'h80); rchk("prio mode", 4, 8'h80);
        wr(0, 8'hC0); irq_seq(ief_pkg::VEC_LOW, 8'h80);
        @(posedge clk_i) ppri <= 8'h01;
        irq_seq(ief_pkg::VEC_HIGH, 8'h00);
        wr(3, 8'h00); wr(4, 8'h00);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1;
        t_regs();
        t_flags();
        t_pins();
        t_irq();
        stop_test();
    end
endmodule
`default_nettype wire
